// File: bench/rsi_top_tb.sv
/*
  Self-checking bench of the reset state initialiser: APB master tasks,
  a register, flag and event model, and pulse monitors on the core outputs.
  Assumes the package constants and the hand-over timing of rsi_top.
*/
`timescale 1ns/100ps
`default_nettype none
module rsi_top_tb;
  import rsi_pkg::*;
  localparam int unsigned WM [0:9] = '{0, 'hff, 'h7f, 'hff, 'hff, 'hff, 'hff, 0, 'h1f, 0};
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        por = 1'b0;
  logic        low_voltage_reset = 1'b0;
  logic        wdt = 1'b0;
  logic        halt = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pc_clr;
  logic        sp_load;
  logic [2:0]  sp_value;
  logic        wdt_clr;
  logic        wdt_run;
  logic        timer_on;
  logic [6:0]  int_en;
  logic [7:0]  port_dir;
  logic        cpu_hold;
  logic        irq;
  logic [31:0] rd;
  logic        er;
  logic [2:0]  sp_exp;
  int unsigned mr [0:9];
  int          errors = 0;
  int          samples_checked = 0;
  int          n_pc = 0;
  int          n_sp = 0;
  int          n_wc = 0;
  int          n_hold = 0;
  int          s_pc, s_sp, s_wc, s_hold;
  int          to_f, pdf_f, ev;

  always #12.5 clk = ~clk;

  rsi_top rsi_top_i (
    .CLK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .POR_DET(por), .LVR_DET(low_voltage_reset), .WDT_EXPIRED(wdt),
    .HALT_STATE(halt), .PC_CLR(pc_clr), .SP_LOAD(sp_load), .SP_VALUE(sp_value),
    .WDT_CLR(wdt_clr), .WDT_RUN(wdt_run), .TIMER_ON(timer_on), .INT_EN(int_en),
    .PORT_DIR(port_dir), .CPU_HOLD(cpu_hold), .IRQ(irq)
  );

  // ==========================================================================
  // Pulse and hold monitors
  always @(posedge clk)
  begin
    n_pc   += (pc_clr === 1'b1);
    n_sp   += (sp_load === 1'b1);
    n_wc   += (wdt_clr === 1'b1);
    n_hold += (cpu_hold === 1'b1);
  end

  // ==========================================================================
  // Reporting and comparison
  task wrap_up();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task chk_rd(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      $display("BAD read t=%0t got=%h exp=%h", $time, got, exp);
      errors++;
    end
  endtask

  task chk_out(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      $display("BAD port t=%0t got=%h exp=%h", $time, got, exp);
      errors++;
    end
  endtask

  // ==========================================================================
  // APB master; every call starts one edge after the previous release
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    if (i == 16)
    begin
      errors++;
      wrap_up();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] exp, input logic e);
    apb(1'b0, a, 32'h0);
    chk_rd(rd, exp);
    chk_rd({31'h0, er}, {31'h0, e});
  endtask

  // ==========================================================================
  // Model helpers
  task full_init();
    mr[1]  = RST_SYSMODE;
    mr[2]  = RST_INTCTL0;
    mr[3]  = RST_TIMERCTL;
    mr[4]  = RST_PORTDIR;
    mr[5]  = RST_WDTCTL;
    mr[6]  = RST_LVSEL;
    sp_exp = SP_TOP;
  endtask

  task scramble(input int unsigned fast);
    int unsigned v;
    for (int i = 1; i <= 6; i++)
    begin
      v = $urandom & WM[i];
      if (i == 1)
        v = (v & 'hfe) | fast;
      apb(1'b1, 8'(i * 4), v);
      mr[i] = v;
    end
  endtask

  task chk_regs();
    for (int i = 1; i <= 8; i++)
      if (i != 7)
        rdc(8'(i * 4), mr[i], 1'b0);
  endtask

  task flags();
    rdc(OFS_STATUS, (to_f << STAT_TO_BIT) | (pdf_f << STAT_PDF_BIT), 1'b0);
  endtask

  task check_ports();
    chk_out({timer_on, int_en, port_dir, sp_value, irq, cpu_hold, wdt_run},
            {mr[3][TIMER_ON_BIT], mr[2][6:0], mr[4][7:0], sp_exp,
             |(ev & mr[8]), 1'b0, 1'b1});
  endtask

  task snap();
    s_pc   = n_pc;
    s_sp   = n_sp;
    s_wc   = n_wc;
    s_hold = n_hold;
  endtask

  task pulses(input int pc, input int sp, input int wc);
    chk_out({n_pc - s_pc, n_sp - s_sp, n_wc - s_wc}, {pc, sp, wc});
  endtask

  // Cause pin held three cycles so only one synced edge is seen
  task cause(input logic p, input logic l, input logic w, input int evb);
    @(posedge clk);
    por <= p;
    low_voltage_reset <= l;
    wdt <= w;
    repeat (3) @(posedge clk);
    por <= 1'b0;
    low_voltage_reset <= 1'b0;
    wdt <= 1'b0;
    repeat (8) @(posedge clk);
    ev |= evb;
  endtask

  task settle(input int lo);
    int i;
    for (i = 0; i < 1200; i++)
    begin
      if (cpu_hold === 1'b0)
        break;
      @(posedge clk);
    end
    if (i == 1200)
    begin
      errors++;
      wrap_up();
    end
    repeat (4) @(posedge clk);
    ev |= 'h10;
    chk_out(n_hold - s_hold >= lo && n_hold - s_hold <= lo + 1, 1);
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    full_init();
    // Event mask is the block's own setting: no reset cause reloads it
    mr[8] = RST_EVMASK;
    to_f  = 0;
    pdf_f = 0;
    ev    = 0;
    void'($urandom(9));
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    // Event bits left by the reset itself are flushed unchecked
    apb(1'b0, OFS_EVSTAT, 32'h0);
    check_ports();
    flags();
    chk_regs();
    rdc(OFS_STATE, 32'h1, 1'b0);
    rdc(8'h28, 32'h0, 1'b1);
    rdc(8'h02, 32'h0, 1'b1);
    // ========================================================================
    // Watchdog in halt, fast then slow clock
    scramble(1);
    @(posedge clk);
    halt <= 1'b1;
    repeat (8) @(posedge clk);
    pdf_f = 1;
    flags();
    rdc(OFS_STATE, 32'h5, 1'b0);
    apb(1'b1, OFS_EVMASK, 32'h8);
    mr[8] = 'h8;
    snap();
    cause(1'b0, 1'b0, 1'b1, 'h8);
    to_f   = 1;
    sp_exp = SP_ZERO;
    chk_out({irq, cpu_hold}, 2'b11);
    settle(SETTLE_FAST_CYCLES);
    pulses(1, 1, 0);
    check_ports();
    flags();
    chk_regs();
    rdc(OFS_EVSTAT, ev, 1'b0);
    ev = 0;
    repeat (2) @(posedge clk);
    chk_out(irq, 1'b0);
    scramble(0);
    snap();
    cause(1'b0, 1'b0, 1'b1, 'h8);
    settle(SETTLE_SLOW_CYCLES);
    pulses(1, 1, 0);
    flags();
    chk_regs();
    @(posedge clk);
    halt <= 1'b0;
    // ========================================================================
    // Low-voltage reset keeps flags, reloads registers
    scramble(1);
    snap();
    cause(1'b0, 1'b1, 1'b0, 'h2);
    full_init();
    pulses(1, 1, 1);
    check_ports();
    flags();
    chk_regs();
    // ========================================================================
    // Running watchdog reset
    apb(1'b1, OFS_STATUS, 32'h20);
    to_f = 0;
    flags();
    scramble(0);
    snap();
    cause(1'b0, 1'b0, 1'b1, 'h4);
    full_init();
    to_f = 1;
    pulses(1, 1, 1);
    check_ports();
    flags();
    chk_regs();
    // ========================================================================
    // Power-on reset, then low-voltage and watchdog together
    scramble(1);
    snap();
    cause(1'b1, 1'b0, 1'b0, 'h1);
    full_init();
    to_f  = 0;
    pdf_f = 0;
    pulses(1, 1, 1);
    check_ports();
    flags();
    chk_regs();
    rdc(OFS_EVSTAT, ev, 1'b0);
    ev = 0;
    cause(1'b0, 1'b1, 1'b1, 'h2);
    flags();
    rdc(OFS_EVSTAT, ev, 1'b0);
    ev = 0;
    check_ports();
    wrap_up();
  end
endmodule
`default_nettype wire

// File: core/rsi_pkg.sv
/*
  Package of the reset state initialiser: register offsets, reset values,
  field positions and settle counts.
  Assumes a 32-bit APB slave with one register per aligned word.
*/
package rsi_pkg;
  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_STATUS   = 8'h00;
  localparam logic [7:0] OFS_SYSMODE  = 8'h04;
  localparam logic [7:0] OFS_INTCTL0  = 8'h08;
  localparam logic [7:0] OFS_TIMERCTL = 8'h0c;
  localparam logic [7:0] OFS_PORTDIR  = 8'h10;
  localparam logic [7:0] OFS_WDTCTL   = 8'h14;
  localparam logic [7:0] OFS_LVSEL    = 8'h18;
  localparam logic [7:0] OFS_EVSTAT   = 8'h1c;
  localparam logic [7:0] OFS_EVMASK   = 8'h20;
  localparam logic [7:0] OFS_STATE    = 8'h24;
  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_SYSMODE  = 8'h03;
  localparam logic [6:0] RST_INTCTL0  = 7'h00;
  localparam logic [7:0] RST_TIMERCTL = 8'h00;
  localparam logic [7:0] RST_PORTDIR  = 8'hff;
  localparam logic [7:0] RST_WDTCTL   = 8'h53;
  localparam logic [7:0] RST_LVSEL    = 8'h55;
  localparam logic [4:0] RST_EVMASK   = 5'h00;
  localparam logic [2:0] SP_TOP       = 3'h7;
  localparam logic [2:0] SP_ZERO      = 3'h0;
  // ==========================================================================
  // Field positions
  localparam int STAT_TO_BIT    = 5;
  localparam int STAT_PDF_BIT   = 4;
  localparam int SYSMODE_FAST   = 0;
  localparam int TIMER_ON_BIT   = 4;
  localparam int EV_POR         = 0;
  localparam int EV_LVR         = 1;
  localparam int EV_WDT_RUN     = 2;
  localparam int EV_WDT_HALT    = 3;
  localparam int EV_SETTLE_DONE = 4;
  localparam int EV_W           = 5;
  localparam int SYNC_W         = 4;
  localparam int IN_POR         = 0;
  localparam int IN_LVR         = 1;
  localparam int IN_WDT         = 2;
  localparam int IN_HALT        = 3;
  // ==========================================================================
  // Wake settle time, in system clock cycles
  localparam int             SETTLE_FAST_CYCLES = 1024;
  localparam int             SETTLE_SLOW_CYCLES = 1;
  localparam int             SETTLE_W           = 11;
  localparam logic [10:0]    SETTLE_FAST_CNT    = SETTLE_FAST_CYCLES[10:0];
  localparam logic [10:0]    SETTLE_SLOW_CNT    = SETTLE_SLOW_CYCLES[10:0];
endpackage

// File: core/rsi_settle.sv
/*
  Wake settle timer: holds the core for a clock-dependent number of cycles
  after a watchdog wake from halt.
  Assumes start is a one-cycle pulse on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module rsi_settle
  import rsi_pkg::*;
(
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic start,
  input  wire logic fast,
  output var  logic busy_r,
  output var  logic done_r
);
  logic [SETTLE_W-1:0] cnt_r;
  logic [SETTLE_W-1:0] cnt_nxt;
  logic                busy_nxt;
  logic                done_nxt;

  // ==========================================================================
  // Countdown
  always_comb
  begin
    cnt_nxt  = cnt_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    if (start)
    begin
      cnt_nxt  = fast ? SETTLE_FAST_CNT : SETTLE_SLOW_CNT;
      busy_nxt = 1'b1;
    end
    else if (busy_r)
    begin
      cnt_nxt = cnt_r - 11'h001;
      if (cnt_r == 11'h001)
      begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_r  <= 11'h000;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      cnt_r  <= cnt_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
    end
  end

  // ==========================================================================
  // Assertions
  // Busy length is counted here; a plain delay that long is too costly
  logic [SETTLE_W-1:0] run_len_r;
  logic [SETTLE_W-1:0] run_len_nxt;
  logic                run_fast_r;
  logic                run_fast_nxt;

  always_comb
  begin
    run_len_nxt  = busy_r ? run_len_r + 11'h001 : 11'h000;
    run_fast_nxt = start ? fast : run_fast_r;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      run_len_r  <= 11'h000;
      run_fast_r <= 1'b0;
    end
    else
    begin
      run_len_r  <= run_len_nxt;
      run_fast_r <= run_fast_nxt;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_fast_settle_len: assert property ($fell(busy_r) && run_fast_r
    |-> run_len_r == SETTLE_FAST_CNT)
    else $error("fast settle length wrong");
endmodule
`default_nettype wire

// File: core/rsi_top.sv
/*
  Reset state initialiser: turns power-on, low-voltage and watchdog reset
  causes into flag updates and initial state for the core, with an APB
  register file and a level interrupt.
  Assumes the reset detectors and halt state arrive asynchronously, and
  that the core acts on the PC and stack pointer load pulses.
*/
`timescale 1ns/100ps
`default_nettype none
module rsi_top
  import rsi_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        ARST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output var  logic [31:0] PRDATA,
  output var  logic        PREADY,
  output var  logic        PSLVERR,
  input  wire logic        POR_DET,
  input  wire logic        LVR_DET,
  input  wire logic        WDT_EXPIRED,
  input  wire logic        HALT_STATE,
  output var  logic        PC_CLR,
  output var  logic        SP_LOAD,
  output var  logic [2:0]  SP_VALUE,
  output var  logic        WDT_CLR,
  output var  logic        WDT_RUN,
  output var  logic        TIMER_ON,
  output var  logic [6:0]  INT_EN,
  output var  logic [7:0]  PORT_DIR,
  output var  logic        CPU_HOLD,
  output var  logic        IRQ
);
  import rsi_pkg::*;

  // ==========================================================================
  // Input synchronisers
  logic [SYNC_W-1:0] pin_in;
  logic [SYNC_W-1:0] meta_r;
  logic [SYNC_W-1:0] sync_r;
  logic [SYNC_W-1:0] prev_r;

  assign pin_in = {HALT_STATE, WDT_EXPIRED, LVR_DET, POR_DET};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++)
    begin : g_sync
      always_ff @(posedge CLK or negedge ARST_N)
      begin
        if (!ARST_N)
        begin
          meta_r[gi] <= 1'b0;
          sync_r[gi] <= 1'b0;
          prev_r[gi] <= 1'b0;
        end
        else
        begin
          meta_r[gi] <= pin_in[gi];
          sync_r[gi] <= meta_r[gi];
          prev_r[gi] <= sync_r[gi];
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Reset cause decode
  logic ev_por;
  logic ev_lvr;
  logic ev_wdt;
  logic in_halt;
  logic halt_entry;
  logic do_full;
  logic do_wdt_run;
  logic do_wdt_halt;

  assign ev_por     = sync_r[IN_POR] & ~prev_r[IN_POR];
  assign ev_lvr     = sync_r[IN_LVR] & ~prev_r[IN_LVR];
  assign ev_wdt     = sync_r[IN_WDT] & ~prev_r[IN_WDT];
  assign in_halt    = sync_r[IN_HALT];
  assign halt_entry = sync_r[IN_HALT] & ~prev_r[IN_HALT];
  // Power-on and low-voltage mask any watchdog cause in the same cycle
  assign do_full     = ev_por | ev_lvr;
  assign do_wdt_run  = ev_wdt & ~do_full & ~in_halt;
  assign do_wdt_halt = ev_wdt & ~do_full & in_halt;

  // ==========================================================================
  // APB decode
  logic        setup_ph;
  logic        acc_ph;
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic [31:0] rd_mux;

  assign setup_ph = PSEL & ~PENABLE;
  assign acc_ph   = PSEL & PENABLE & PREADY;
  assign wr_en    = acc_ph & PWRITE & ~PSLVERR;
  assign rd_en    = acc_ph & ~PWRITE & ~PSLVERR;
  assign addr_ok  = (PADDR <= OFS_STATE) && (PADDR[1:0] == 2'b00);

  // ==========================================================================
  // Register state
  logic              to_r, to_nxt;
  logic              pdf_r, pdf_nxt;
  logic [7:0]        sysmode_r, sysmode_nxt;
  logic [6:0]        intctl_r, intctl_nxt;
  logic [7:0]        timerctl_r, timerctl_nxt;
  logic [7:0]        portdir_r, portdir_nxt;
  logic [7:0]        wdtctl_r, wdtctl_nxt;
  logic [7:0]        lvsel_r, lvsel_nxt;
  logic [EV_W-1:0]   evstat_r, evstat_nxt;
  logic [EV_W-1:0]   evmask_r, evmask_nxt;
  logic [EV_W-1:0]   ev_set;
  logic              settle_busy;
  logic              settle_done;

  assign ev_set = {settle_done, do_wdt_halt, do_wdt_run, ev_lvr, ev_por};

  always_comb
  begin
    to_nxt       = to_r;
    pdf_nxt      = pdf_r;
    sysmode_nxt  = sysmode_r;
    intctl_nxt   = intctl_r;
    timerctl_nxt = timerctl_r;
    portdir_nxt  = portdir_r;
    wdtctl_nxt   = wdtctl_r;
    lvsel_nxt    = lvsel_r;
    evmask_nxt   = evmask_r;
    evstat_nxt   = evstat_r;
    // Software writes first, so the reset loads and flag updates below override them
    if (wr_en)
    begin
      case (PADDR)
        OFS_STATUS:
        begin
          // Write one to clear either flag
          if (PWDATA[STAT_TO_BIT])
            to_nxt = 1'b0;
          if (PWDATA[STAT_PDF_BIT])
            pdf_nxt = 1'b0;
        end
        OFS_SYSMODE:  sysmode_nxt  = PWDATA[7:0];
        OFS_INTCTL0:  intctl_nxt   = PWDATA[6:0];
        OFS_TIMERCTL: timerctl_nxt = PWDATA[7:0];
        OFS_PORTDIR:  portdir_nxt  = PWDATA[7:0];
        OFS_WDTCTL:   wdtctl_nxt   = PWDATA[7:0];
        OFS_LVSEL:    lvsel_nxt    = PWDATA[7:0];
        OFS_EVMASK:   evmask_nxt   = PWDATA[EV_W-1:0];
        default:      ;
      endcase
    end
    if (rd_en && PADDR == OFS_EVSTAT)
      evstat_nxt = '0;
    // A new event wins over the read that clears it
    evstat_nxt = evstat_nxt | ev_set;
    if (halt_entry)
      pdf_nxt = 1'b1;
    if (do_full || do_wdt_run)
    begin
      // Same values for power-on, low-voltage and running watchdog
      sysmode_nxt  = RST_SYSMODE;
      intctl_nxt   = RST_INTCTL0;
      timerctl_nxt = RST_TIMERCTL;
      portdir_nxt  = RST_PORTDIR;
      wdtctl_nxt   = RST_WDTCTL;
      lvsel_nxt    = RST_LVSEL;
    end
    if (ev_por)
    begin
      to_nxt  = 1'b0;
      pdf_nxt = 1'b0;
    end
    else if (ev_lvr)
    begin
      to_nxt  = to_r;
      pdf_nxt = pdf_r;
    end
    else if (do_wdt_run)
    begin
      to_nxt  = 1'b1;
      pdf_nxt = pdf_r;
    end
    else if (do_wdt_halt)
    begin
      to_nxt  = 1'b1;
      pdf_nxt = 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      to_r       <= 1'b0;
      pdf_r      <= 1'b0;
      sysmode_r  <= RST_SYSMODE;
      intctl_r   <= RST_INTCTL0;
      timerctl_r <= RST_TIMERCTL;
      portdir_r  <= RST_PORTDIR;
      wdtctl_r   <= RST_WDTCTL;
      lvsel_r    <= RST_LVSEL;
      evstat_r   <= '0;
      evmask_r   <= RST_EVMASK;
    end
    else
    begin
      to_r       <= to_nxt;
      pdf_r      <= pdf_nxt;
      sysmode_r  <= sysmode_nxt;
      intctl_r   <= intctl_nxt;
      timerctl_r <= timerctl_nxt;
      portdir_r  <= portdir_nxt;
      wdtctl_r   <= wdtctl_nxt;
      lvsel_r    <= lvsel_nxt;
      evstat_r   <= evstat_nxt;
      evmask_r   <= evmask_nxt;
    end
  end

  // ==========================================================================
  // Wake settle
  rsi_settle u_settle (
    .clk    (CLK),
    .arst_n (ARST_N),
    .start  (do_wdt_halt),
    .fast   (sysmode_r[SYSMODE_FAST]),
    .busy_r (settle_busy),
    .done_r (settle_done)
  );

  // ==========================================================================
  // Core-facing outputs and APB answer
  logic        pc_clr_nxt;
  logic        sp_load_nxt;
  logic [2:0]  sp_value_nxt;
  logic        wdt_clr_nxt;
  logic        pready_nxt;
  logic        pslverr_nxt;
  logic [31:0] prdata_nxt;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (PADDR)
      OFS_STATUS:   rd_mux = {26'h0, to_r, pdf_r, 4'h0};
      OFS_SYSMODE:  rd_mux = {24'h0, sysmode_r};
      OFS_INTCTL0:  rd_mux = {25'h0, intctl_r};
      OFS_TIMERCTL: rd_mux = {24'h0, timerctl_r};
      OFS_PORTDIR:  rd_mux = {24'h0, portdir_r};
      OFS_WDTCTL:   rd_mux = {24'h0, wdtctl_r};
      OFS_LVSEL:    rd_mux = {24'h0, lvsel_r};
      OFS_EVSTAT:   rd_mux = {27'h0, evstat_r};
      OFS_EVMASK:   rd_mux = {27'h0, evmask_r};
      OFS_STATE:    rd_mux = {29'h0, in_halt, settle_busy, WDT_RUN};
      default:      rd_mux = 32'h0000_0000;
    endcase
  end

  always_comb
  begin
    // Every cause restarts at address zero
    pc_clr_nxt   = do_full | do_wdt_run | do_wdt_halt;
    sp_load_nxt  = do_full | do_wdt_run | do_wdt_halt;
    sp_value_nxt = SP_VALUE;
    if (do_wdt_halt)
      sp_value_nxt = SP_ZERO;
    else if (do_full || do_wdt_run)
      sp_value_nxt = SP_TOP;
    wdt_clr_nxt = do_full | do_wdt_run;
    pready_nxt  = setup_ph;
    pslverr_nxt = setup_ph & ~addr_ok;
    prdata_nxt  = setup_ph ? rd_mux : PRDATA;
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      PC_CLR   <= 1'b0;
      SP_LOAD  <= 1'b0;
      SP_VALUE <= SP_TOP;
      WDT_CLR  <= 1'b0;
      WDT_RUN  <= 1'b0;
      TIMER_ON <= 1'b0;
      INT_EN   <= RST_INTCTL0;
      PORT_DIR <= RST_PORTDIR;
      CPU_HOLD <= 1'b0;
      IRQ      <= 1'b0;
      PREADY   <= 1'b0;
      PSLVERR  <= 1'b0;
      PRDATA   <= 32'h0000_0000;
    end
    else
    begin
      PC_CLR   <= pc_clr_nxt;
      SP_LOAD  <= sp_load_nxt;
      SP_VALUE <= sp_value_nxt;
      WDT_CLR  <= wdt_clr_nxt;
      WDT_RUN  <= 1'b1;
      TIMER_ON <= timerctl_nxt[TIMER_ON_BIT];
      INT_EN   <= intctl_nxt;
      PORT_DIR <= portdir_nxt;
      CPU_HOLD <= settle_busy | do_wdt_halt;
      IRQ      <= |(evstat_nxt & evmask_nxt);
      PREADY   <= pready_nxt;
      PSLVERR  <= pslverr_nxt;
      PRDATA   <= prdata_nxt;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  a_por_flags_clear: assert property (ev_por |=> !to_r && !pdf_r)
    else $error("power-on did not clear flags");
  a_lvr_flags_keep: assert property (ev_lvr && !ev_por && !halt_entry && !wr_en
    |=> to_r == $past(to_r) && pdf_r == $past(pdf_r))
    else $error("low-voltage reset changed flags");
  a_wdt_run_flags: assert property (do_wdt_run && !halt_entry && !wr_en
    |=> to_r && pdf_r == $past(pdf_r))
    else $error("running watchdog flags wrong");
  a_wdt_halt_flags: assert property (do_wdt_halt |=> to_r && pdf_r)
    else $error("halt watchdog flags wrong");
  a_halt_sp_zero: assert property (do_wdt_halt |=> SP_LOAD && PC_CLR && SP_VALUE == 3'h0)
    else $error("halt watchdog did not zero pc and sp");
  a_halt_keeps_cfg: assert property (do_wdt_halt && !wr_en |=> portdir_r == $past(portdir_r))
    else $error("halt watchdog changed port direction");
  a_full_init_vals: assert property (do_full |=> PORT_DIR == 8'hff && INT_EN == 7'h00
    && !TIMER_ON && WDT_CLR && SP_VALUE == 3'h7)
    else $error("full reset init values wrong");
  a_slow_settle_len: assert property (do_wdt_halt && !sysmode_r[SYSMODE_FAST]
    |=> CPU_HOLD ##1 CPU_HOLD ##1 !CPU_HOLD)
    else $error("slow settle length wrong");
  a_priority_full: assert property (ev_wdt && do_full |=> WDT_CLR && SP_VALUE == 3'h7)
    else $error("watchdog beat power-on init");
  a_apb_one_wait: assert property (setup_ph |=> PREADY)
    else $error("apb answer late");

  c_por: cover property (ev_por ##1 PC_CLR);
  c_wdt_halt_fast: cover property (do_wdt_halt && sysmode_r[SYSMODE_FAST]);
  c_wdt_run: cover property (do_wdt_run ##1 WDT_CLR);
  c_irq: cover property (IRQ);
endmodule
`default_nettype wire
